// ---- dfs_regs.vh ----
// register offsets, field positions, reset values and timing counts of the dwell sequencer
`ifndef DFS_REGS_VH
`define DFS_REGS_VH
`define DFS_OFF_CTRL 8'h00
`define DFS_OFF_ACC_FREQ 8'h04
`define DFS_OFF_ACC_TIME 8'h08
`define DFS_OFF_DEC_FREQ 8'h0c
`define DFS_OFF_DEC_TIME 8'h10
`define DFS_OFF_TARGET 8'h14
`define DFS_OFF_ACC_RATE 8'h18
`define DFS_OFF_DEC_RATE 8'h1c
`define DFS_OFF_STATUS 8'h20
`define DFS_CTRL_RUN 0
`define DFS_CTRL_BRAKE 1
`define DFS_STAT_STATE_LSB 16
`define DFS_STAT_ACCDONE 24
`define DFS_STAT_DECDONE 25
`define DFS_RST_DWELL_FREQ 16'h01f4
`define DFS_RST_DWELL_TIME 7'h00
`define DFS_MAX_DWELL_TIME 7'h64
`define DFS_RST_TARGET 16'h0000
`define DFS_RST_RATE 16'h000a
`define DFS_CLK_PERIOD_NS 4
`define DFS_TENTH_SEC_NS 100000000
`define DFS_RAMP_TICK_NS 1000000
`define DFS_TENTH_CYCLES (`DFS_TENTH_SEC_NS / `DFS_CLK_PERIOD_NS)
`define DFS_RAMP_CYCLES (`DFS_RAMP_TICK_NS / `DFS_CLK_PERIOD_NS)
`endif

// ---- dfs_dwell_sequencer.v ----
// dwell frequency sequencer: run/stop ramp generator with dwell plateaus, apb registers
//
// Behaviour
// - run ramps, holds accel dwell, then accelerates
// - stop ramps, holds decel dwell, then continues
// - after decel dwell, use configured decel rate
// - zero time or zero frequency skips dwell
// - accel dwell only on first run command
// - decel dwell only after a stop command
// - external brake control disables all dwell
// - dwell freq start..max, 5.00 Hz; time 0..10 s
//
// Implementation choices: the APB slave port and the register offsets.
`include "dfs_regs.vh"
module dfs_dwell_sequencer #(
    parameter [15:0] START_FREQ = 16'h0032, // lowest settable dwell frequency, 0.01 Hz
    parameter [15:0] MAX_FREQ = 16'h1770, // highest settable frequency, 0.01 Hz
    parameter integer TENTH_CYCLES = `DFS_TENTH_CYCLES, // clocks per 0.1 s
    parameter integer RAMP_CYCLES = `DFS_RAMP_CYCLES // clocks per ramp step
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg [15:0] outFreq,
    output reg dwellActive
);
    // one-hot states
    localparam [4:0] ST_STOP = 5'h01;
    localparam [4:0] ST_RUN = 5'h02;
    localparam [4:0] ST_ADW = 5'h04;
    localparam [4:0] ST_DECEL = 5'h08;
    localparam [4:0] ST_DDW = 5'h10;

    // software registers
    reg runCmd_q; // run command bit
    reg brakeEn_q; // external brake control active
    reg [15:0] accFreq_q; // accel dwell frequency
    reg [6:0] accTime_q; // accel dwell time, tenths of a second
    reg [15:0] decFreq_q; // decel dwell frequency
    reg [6:0] decTime_q; // decel dwell time, tenths of a second
    reg [15:0] target_q; // commanded frequency
    reg [15:0] accRate_q; // accel step per ramp tick
    reg [15:0] decRate_q; // decel step per ramp tick
    // sequencer state
    reg [4:0] state_q;
    reg accDone_q; // accel dwell already consumed for this run
    reg decDone_q; // decel dwell already consumed for this stop
    reg [6:0] holdCnt_q; // tenths left in a dwell
    reg [31:0] tenthDiv_q; // tenth-second prescaler
    reg [31:0] rampDiv_q; // ramp-step prescaler

    // bus decode
    wire setupPh = psel & ~penable;
    wire accessWr = psel & penable & pwrite;
    reg mapped; // address hits a register
    reg [31:0] rdMux; // read data selected by address
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // clamp a dwell frequency into the settable range
    function [15:0] clampFreq;
        input [15:0] v;
        begin
            if (v == 16'h0000) begin
                clampFreq = 16'h0000; // zero kept so the dwell can be switched off
            end else if (v < START_FREQ) begin
                clampFreq = START_FREQ;
            end else if (v > MAX_FREQ) begin
                clampFreq = MAX_FREQ;
            end else begin
                clampFreq = v;
            end
        end
    endfunction

    // clamp a dwell time to ten seconds
    function [6:0] clampTime;
        input [31:0] v;
        begin
            if (v > {25'h0000000, `DFS_MAX_DWELL_TIME}) begin
                clampTime = `DFS_MAX_DWELL_TIME;
            end else begin
                clampTime = v[6:0];
            end
        end
    endfunction

    // ramp and tenth-second enable pulses
    wire rampTick = (rampDiv_q == RAMP_CYCLES - 1);
    wire tenthTick = (tenthDiv_q == TENTH_CYCLES - 1);
    // dwell enables
    wire accDwellOn = (accFreq_q != 16'h0000) & (accTime_q != 7'h00) & ~brakeEn_q;
    wire decDwellOn = (decFreq_q != 16'h0000) & (decTime_q != 7'h00) & ~brakeEn_q;
    // ramp arithmetic
    wire [15:0] tgt = (target_q > MAX_FREQ) ? MAX_FREQ : target_q;
    wire [16:0] upSum = {1'b0, outFreq} + {1'b0, accRate_q};
    wire [15:0] upNext = (upSum[15:0] > tgt || upSum[16]) ? tgt : upSum[15:0];
    wire [15:0] dnStep = (outFreq > decRate_q) ? outFreq - decRate_q : 16'h0000;
    wire [15:0] dnTrack = (dnStep < tgt) ? tgt : dnStep;

    // read multiplexer and address decode
    always @* begin
        mapped = 1'b1;
        rdMux = 32'h00000000;
        case (paddr)
            `DFS_OFF_CTRL: begin
                rdMux[`DFS_CTRL_RUN] = runCmd_q;
                rdMux[`DFS_CTRL_BRAKE] = brakeEn_q;
            end
            `DFS_OFF_ACC_FREQ: rdMux[15:0] = accFreq_q;
            `DFS_OFF_ACC_TIME: rdMux[6:0] = accTime_q;
            `DFS_OFF_DEC_FREQ: rdMux[15:0] = decFreq_q;
            `DFS_OFF_DEC_TIME: rdMux[6:0] = decTime_q;
            `DFS_OFF_TARGET: rdMux[15:0] = target_q;
            `DFS_OFF_ACC_RATE: rdMux[15:0] = accRate_q;
            `DFS_OFF_DEC_RATE: rdMux[15:0] = decRate_q;
            `DFS_OFF_STATUS: begin
                rdMux[15:0] = outFreq;
                rdMux[`DFS_STAT_STATE_LSB +: 5] = state_q;
                rdMux[`DFS_STAT_ACCDONE] = accDone_q;
                rdMux[`DFS_STAT_DECDONE] = decDone_q;
            end
            default: mapped = 1'b0; // unmapped: reads zero, error in access phase
        endcase
    end

    // read data captured in the setup phase, stable through access
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (setupPh) begin
            prdata <= rdMux;
        end
    end

    // register writes take effect at the access edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            runCmd_q <= 1'b0;
            brakeEn_q <= 1'b0;
            accFreq_q <= `DFS_RST_DWELL_FREQ;
            accTime_q <= `DFS_RST_DWELL_TIME;
            decFreq_q <= `DFS_RST_DWELL_FREQ;
            decTime_q <= `DFS_RST_DWELL_TIME;
            target_q <= `DFS_RST_TARGET;
            accRate_q <= `DFS_RST_RATE;
            decRate_q <= `DFS_RST_RATE;
        end else if (accessWr) begin
            case (paddr)
                `DFS_OFF_CTRL: begin
                    runCmd_q <= pwdata[`DFS_CTRL_RUN];
                    brakeEn_q <= pwdata[`DFS_CTRL_BRAKE];
                end
                `DFS_OFF_ACC_FREQ: accFreq_q <= clampFreq(pwdata[15:0]);
                `DFS_OFF_ACC_TIME: accTime_q <= clampTime(pwdata);
                `DFS_OFF_DEC_FREQ: decFreq_q <= clampFreq(pwdata[15:0]);
                `DFS_OFF_DEC_TIME: decTime_q <= clampTime(pwdata);
                `DFS_OFF_TARGET: target_q <= pwdata[15:0];
                `DFS_OFF_ACC_RATE: accRate_q <= pwdata[15:0];
                `DFS_OFF_DEC_RATE: decRate_q <= pwdata[15:0];
                default: begin
                    // read-only or unmapped: nothing stored
                end
            endcase
        end
    end

    // ramp prescaler, free running
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rampDiv_q <= 32'h00000000;
        end else if (rampTick) begin
            rampDiv_q <= 32'h00000000;
        end else begin
            rampDiv_q <= rampDiv_q + 32'h00000001;
        end
    end

    // tenth prescaler, restarted whenever no dwell is held so each hold is exact
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tenthDiv_q <= 32'h00000000;
        end else if (!dwellActive || tenthTick) begin
            tenthDiv_q <= 32'h00000000;
        end else begin
            tenthDiv_q <= tenthDiv_q + 32'h00000001;
        end
    end

    // sequencer
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_STOP;
            outFreq <= 16'h0000;
            accDone_q <= 1'b0;
            decDone_q <= 1'b0;
            holdCnt_q <= 7'h00;
            dwellActive <= 1'b0;
        end else begin
            case (state_q)
                // standstill: a run command starts a fresh run
                ST_STOP: begin
                    outFreq <= 16'h0000;
                    dwellActive <= 1'b0;
                    if (runCmd_q) begin
                        accDone_q <= 1'b0;
                        state_q <= ST_RUN;
                    end
                end
                // run: track the commanded frequency
                ST_RUN: begin
                    if (!runCmd_q) begin
                        decDone_q <= 1'b0;
                        state_q <= ST_DECEL;
                    end else if (rampTick) begin
                        if (outFreq < tgt) begin
                            if (!accDone_q && accDwellOn && outFreq < accFreq_q &&
                                    upNext >= accFreq_q && tgt >= accFreq_q) begin
                                outFreq <= accFreq_q;
                                holdCnt_q <= accTime_q;
                                dwellActive <= 1'b1;
                                accDone_q <= 1'b1;
                                state_q <= ST_ADW;
                            end else begin
                                outFreq <= upNext;
                            end
                        end else begin
                            outFreq <= dnTrack; // plain reduction, no dwell
                        end
                    end
                end
                // accel dwell hold
                ST_ADW: begin
                    if (!runCmd_q) begin
                        dwellActive <= 1'b0;
                        decDone_q <= 1'b0;
                        state_q <= ST_DECEL;
                    end else if (brakeEn_q) begin
                        dwellActive <= 1'b0;
                        state_q <= ST_RUN;
                    end else if (tenthTick) begin
                        if (holdCnt_q <= 7'h01) begin
                            dwellActive <= 1'b0;
                            state_q <= ST_RUN;
                        end
                        holdCnt_q <= holdCnt_q - 7'h01;
                    end
                end
                // stop ramp toward zero
                ST_DECEL: begin
                    if (runCmd_q) begin
                        state_q <= ST_RUN; // re-accel keeps accDone
                    end else if (outFreq == 16'h0000) begin
                        state_q <= ST_STOP;
                    end else if (rampTick) begin
                        if (!decDone_q && decDwellOn && outFreq > decFreq_q &&
                                dnStep <= decFreq_q) begin
                            outFreq <= decFreq_q;
                            holdCnt_q <= decTime_q;
                            dwellActive <= 1'b1;
                            decDone_q <= 1'b1;
                            state_q <= ST_DDW;
                        end else begin
                            outFreq <= dnStep;
                        end
                    end
                end
                // decel dwell hold
                ST_DDW: begin
                    if (runCmd_q) begin
                        dwellActive <= 1'b0;
                        state_q <= ST_RUN;
                    end else if (brakeEn_q) begin
                        dwellActive <= 1'b0;
                        state_q <= ST_DECEL;
                    end else if (tenthTick) begin
                        if (holdCnt_q <= 7'h01) begin
                            dwellActive <= 1'b0;
                            state_q <= ST_DECEL;
                        end
                        holdCnt_q <= holdCnt_q - 7'h01;
                    end
                end
                default: begin
                    state_q <= ST_STOP;
                    outFreq <= 16'h0000;
                    dwellActive <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ---- dfs_dwell_sequencer_props.sv ----
// port-level assertion checker for the dwell frequency sequencer
module dfs_dwell_sequencer_props #(
    parameter integer TENTH_CYCLES = 20,
    parameter integer RAMP_CYCLES = 4
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [15:0] outFreq,
    input wire dwellActive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dfsCb @(posedge clk); endclocking
    default disable iff (!nrst);
    reg [15:0] prevFreq_q; // output frequency one clock ago
    reg [7:0] sinceChg_q; // clocks since the last frequency step, saturating
    reg [31:0] dwellLen_q; // clocks the current plateau has lasted
    // step spacing and plateau length trackers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevFreq_q <= 16'h0000;
            sinceChg_q <= 8'hff;
            dwellLen_q <= 32'h0;
        end else begin
            prevFreq_q <= outFreq;
            sinceChg_q <= (outFreq != prevFreq_q) ? 8'h00 : sinceChg_q + {7'h0, sinceChg_q != 8'hff};
            dwellLen_q <= dwellActive ? dwellLen_q + 32'h1 : 32'h0;
        end
    end
    a_ready_const: assert property (pready)
        else $error("pready dropped");
    a_err_access_only: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside an access phase");
    a_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("no error on unmapped address");
    a_rdata_unmapped: assert property (psel && !penable && !pwrite && paddr > 8'h20 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_held: assert property (psel && !penable ##1 psel && penable |=> $stable(prdata))
        else $error("read data moved during access");
    a_dwell_steady: assert property (dwellActive && $past(dwellActive) |-> $stable(outFreq))
        else $error("frequency moved during plateau");
    a_dwell_nonzero: assert property (dwellActive |-> outFreq != 16'h0)
        else $error("plateau at zero frequency");
    a_step_spacing: assert property (outFreq != prevFreq_q |-> sinceChg_q >= RAMP_CYCLES - 1)
        else $error("frequency stepped between ramp ticks");
    a_dwell_bounded: assert property (dwellLen_q <= 100 * TENTH_CYCLES + 2 * RAMP_CYCLES + 2)
        else $error("plateau longer than ten seconds");
    c_dwell: cover property ($rose(dwellActive));
    c_err: cover property (pslverr);
    c_stop: cover property ($fell(|outFreq));
endmodule

bind dfs_dwell_sequencer dfs_dwell_sequencer_props #(.TENTH_CYCLES(TENTH_CYCLES),
    .RAMP_CYCLES(RAMP_CYCLES)) dfs_props_i (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outFreq(outFreq), .dwellActive(dwellActive));

// ---- dfs_motor_model.sv ----
// behavioural motor: shaft frequency slews toward the drive command with inertia
module dfs_motor_model (
    input wire clk,
    input wire nrst,
    input wire [15:0] driveFreq,
    output logic [15:0] shaftFreq
);
    timeunit 1ns;
    timeprecision 1ps;
    // at most 16 counts per clock, fast enough to follow any ramp used here
    always @(posedge clk or negedge nrst) begin
        if (!nrst) shaftFreq <= 16'h0;
        else if (driveFreq > shaftFreq + 16'h10) shaftFreq <= shaftFreq + 16'h10;
        else if (driveFreq + 16'h10 < shaftFreq) shaftFreq <= shaftFreq - 16'h10;
        else shaftFreq <= driveFreq;
    end
endmodule

// ---- dfs_dwell_sequencer_tb.sv ----
// self-checking bench for the dwell frequency sequencer
`include "dfs_regs.vh"
module dfs_dwell_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer TENTH = 20; // clocks per tenth in simulation
    localparam integer RAMP = 4; // clocks per ramp step
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} dfsNote_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, dwellActive;
    wire [15:0] outFreq, shaftFreq;
    logic [31:0] rstVal [10] = '{32'h0, 32'h1f4, 32'h0, 32'h1f4, 32'h0, 32'h0, 32'ha, 32'ha,
        32'h10000, 32'h0}; // reset value of every slot, last one unmapped
    dfsNote_t noteQ[$]; // expected read results, oldest first
    dfsNote_t note;
    int fail_count = 0;
    int total_checks = 0;
    int dwellClk = 0; // clocks with a plateau observed, written by the monitor only
    int mark; // dwellClk at the start of a check window
    int dwellLen = 0; // clocks of the current plateau
    int lastLen = 0; // clocks of the last finished plateau
    logic [15:0] rnd;
    always #2 clk = ~clk;
    dfs_dwell_sequencer #(.TENTH_CYCLES(TENTH), .RAMP_CYCLES(RAMP)) dfs_dwell_sequencer_i (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outFreq(outFreq), .dwellActive(dwellActive));
    dfs_motor_model dfs_motor_model_i (.clk(clk), .nrst(nrst), .driveFreq(outFreq),
        .shaftFreq(shaftFreq));
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read monitor matches each completed read to the oldest note; plateau tracker
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && noteQ.size() > 0) begin
            note = noteQ.pop_front();
            chk(prdata & note.mask, note.exp);
            chk({31'h0, pslverr}, {31'h0, note.err});
        end
        if (dwellActive === 1'b1) begin
            dwellClk <= dwellClk + 1;
            dwellLen <= dwellLen + 1;
        end else if (dwellLen != 0) begin
            lastLen <= dwellLen;
            dwellLen <= 0;
        end
    end
    // one apb transfer, request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
        input logic er);
        noteQ.push_back('{e, m, er});
        apb(1'b0, a, 32'h0);
    endtask
    // bounded wait: 0 frequency equal, 1 plateau, 2 frequency below f but nonzero
    task automatic waitOn(input int k, input logic [15:0] f);
        int n;
        for (n = 0; n < 20000; n++) begin
            if (k == 0 && outFreq === f) break;
            if (k == 1 && dwellActive === 1'b1) break;
            if (k == 2 && outFreq < f && outFreq !== 16'h0) break;
            @(posedge clk);
        end
        if (n == 20000) begin
            fail_count++;
            test_done();
        end
    endtask
    initial begin
        #300000;
        fail_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h0b07));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd(8'(4 * i), rstVal[i], '1, i == 9);
        apb(1'b1, `DFS_OFF_ACC_TIME, 32'd200);
        rd(`DFS_OFF_ACC_TIME, 32'h64, '1, 1'b0);
        rnd = 16'h0032 + 16'($urandom % 32'h173f);
        apb(1'b1, `DFS_OFF_DEC_FREQ, {16'h0, rnd});
        rd(`DFS_OFF_DEC_FREQ, {16'h0, rnd}, '1, 1'b0);
        apb(1'b1, `DFS_OFF_ACC_FREQ, 32'h10);
        rd(`DFS_OFF_ACC_FREQ, 32'h32, '1, 1'b0);
        apb(1'b1, `DFS_OFF_DEC_FREQ, 32'hffff);
        rd(`DFS_OFF_DEC_FREQ, 32'h1770, '1, 1'b0);
        $display("test registers done");
        apb(1'b1, `DFS_OFF_ACC_FREQ, 32'h64);
        apb(1'b1, `DFS_OFF_ACC_TIME, 32'h2);
        apb(1'b1, `DFS_OFF_DEC_FREQ, 32'h64);
        apb(1'b1, `DFS_OFF_DEC_TIME, 32'h1);
        apb(1'b1, `DFS_OFF_TARGET, 32'h200);
        apb(1'b1, `DFS_OFF_CTRL, 32'h1);
        waitOn(1, 16'h0);
        rd(`DFS_OFF_STATUS, 32'h00040064, 32'h001fffff, 1'b0);
        waitOn(0, 16'h200);
        chk(32'(lastLen >= 2 * TENTH && lastLen <= 2 * TENTH + RAMP + 1), 32'h1);
        rd(`DFS_OFF_STATUS, 32'h01020200, 32'h011fffff, 1'b0);
        apb(1'b1, `DFS_OFF_CTRL, 32'h0);
        waitOn(1, 16'h0);
        rd(`DFS_OFF_STATUS, 32'h00100064, 32'h001fffff, 1'b0);
        waitOn(0, 16'h0);
        chk(32'(lastLen >= TENTH && lastLen <= TENTH + RAMP + 1), 32'h1);
        rd(`DFS_OFF_STATUS, 32'h02010000, 32'h021fffff, 1'b0);
        $display("test dwell plateaus done");
        apb(1'b1, `DFS_OFF_DEC_TIME, 32'h0);
        apb(1'b1, `DFS_OFF_CTRL, 32'h1);
        waitOn(0, 16'h200);
        mark = dwellClk;
        apb(1'b1, `DFS_OFF_CTRL, 32'h0);
        waitOn(2, 16'h64);
        apb(1'b1, `DFS_OFF_CTRL, 32'h1);
        waitOn(0, 16'h200);
        chk(32'(dwellClk - mark), 32'h0);
        apb(1'b1, `DFS_OFF_DEC_TIME, 32'h1);
        mark = dwellClk;
        apb(1'b1, `DFS_OFF_TARGET, 32'h48);
        waitOn(0, 16'h48);
        chk(32'(dwellClk - mark), 32'h0);
        $display("test re-acceleration and slowdown done");
        apb(1'b1, `DFS_OFF_CTRL, 32'h2);
        waitOn(0, 16'h0);
        apb(1'b1, `DFS_OFF_TARGET, 32'h200);
        mark = dwellClk;
        apb(1'b1, `DFS_OFF_CTRL, 32'h3);
        waitOn(0, 16'h200);
        apb(1'b1, `DFS_OFF_CTRL, 32'h2);
        waitOn(0, 16'h0);
        chk(32'(dwellClk - mark), 32'h0);
        $display("test brake control done");
        apb(1'b1, `DFS_OFF_DEC_TIME, 32'h0);
        apb(1'b1, `DFS_OFF_ACC_FREQ, 32'h0);
        mark = dwellClk;
        apb(1'b1, `DFS_OFF_CTRL, 32'h1);
        waitOn(0, 16'h200);
        apb(1'b1, `DFS_OFF_CTRL, 32'h0);
        waitOn(0, 16'h0);
        chk(32'(dwellClk - mark), 32'h0);
        $display("test zero dwell frequency done");
        apb(1'b1, `DFS_OFF_ACC_FREQ, 32'h64);
        apb(1'b1, `DFS_OFF_ACC_TIME, 32'h5);
        apb(1'b1, `DFS_OFF_CTRL, 32'h1);
        waitOn(1, 16'h0);
        apb(1'b1, `DFS_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, dwellActive}, 32'h0);
        waitOn(0, 16'h0);
        repeat (50) @(posedge clk);
        chk({16'h0, shaftFreq}, 32'h0);
        $display("test stop during plateau done");
        test_done();
    end
endmodule
